// *** src/port_a_defs.svh ***
// register offsets, field masks and reset values of the port A pin control block
`ifndef PORT_A_DEFS_SVH
`define PORT_A_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on the 24-bit register port)
// ----------------------------------------------------------------------------
`define PA_DATA_ADDR   24'hffffe9
`define PA_PULL_ADDR   24'hff0019
`define PA_FUNC_ADDR   24'hff0009
`define PA_DIR_ADDR    24'hfffff9

// ----------------------------------------------------------------------------
// implemented bits of each register, unimplemented bits read zero
// ----------------------------------------------------------------------------
`define PA_FUNC_MASK   8'hf4
`define PA_DIR_MASK    8'hf0
`define PA_DATA_MASK   8'hf0
`define PA_PULL_MASK   8'hf0
`define PA_ANALOG_BIT  2
`define PA_PIN_LO      4
`define PA_PIN_HI      7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PA_FUNC_RST    8'h00
`define PA_DIR_RST     8'h00
`define PA_DATA_RST    8'h00
`define PA_PULL_RST    8'h00

`endif

// *** src/port_a_pkg.sv ***
// types shared by the port A pin control modules
package port_a_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [23:0] addr_t;

    // software visible state of the port plus the read data register
    typedef struct packed {
        byte_t func;
        byte_t dir;
        byte_t data;
        byte_t pull;
        byte_t rdata;
    } regs_s;

endpackage

// *** src/pin_sync.sv ***
// two flip-flop synchroniser for the pin levels
`timescale 1ns/100ps
module pin_sync
    import port_a_pkg::*;
#(
    parameter int WIDTH = 4
)(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // first stage only feeds the second, nothing else looks at it
    always_comb
    begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sync_out = s_q.sync;

endmodule

// *** src/pin_mux.sv ***
// per-pin selection between general i/o and the mapped alternate function
`timescale 1ns/100ps
module pin_mux
    import port_a_pkg::*;
#(
    parameter int WIDTH = 4
)(
    // register fields
    input  wire logic [WIDTH-1:0] func,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] data,
    input  wire logic [WIDTH-1:0] pull,
    // alternate function from the mapping controller
    input  wire logic [WIDTH-1:0] alt_out,
    input  wire logic [WIDTH-1:0] alt_oe,
    // pin side
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n,
    output logic      [WIDTH-1:0] pullup_en
);

    logic [WIDTH-1:0] drive;

    // function bit picks the source, direction only counts in general i/o mode
    always_comb
    begin
        drive     = (~func & dir) | (func & alt_oe);   // R01 R04
        pin_out   = (func & alt_out) | (~func & data); // R01
        pin_oe_n  = ~drive;                            // R04
        // pull-up only on a pin that is not being driven
        pullup_en = pull & ~drive;                     // R07
    end

endmodule

// *** src/port_a_ctrl.sv ***
// port A multiplexed pin control: mode, direction, data and pull-up registers
//
// How it works
// R01: mode bit 0 gives pins 7..4 to general i/o, 1 to the mapped function.
// R02: mode bit 2 routes neighbour pin 0 to analog channel zero when set.
// R03: mode bits 3,1,0 and direction bits 3..0 always read zero.
// R04: in general i/o, direction 1 drives the pin, 0 leaves it input.
// R05: port pins are offered as analog inputs to converter units 1 and 2.
// R06: data read gives stored value on outputs, live pin level on inputs.
// R07: pull-up acts only on pins that are inputs; software clears it for analog.
// R08: after reset every pin is a general i/o input, no alternate or analog.
`timescale 1ns/100ps
`include "port_a_defs.svh"
module port_a_ctrl
    import port_a_pkg::*;
#(
    parameter int PINS = 4
)(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            nrst,
    // register port
    input  wire logic [23:0]     reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    // port pins 7..4
    input  wire logic [PINS-1:0] pin_in,
    output logic      [PINS-1:0] pin_out,
    output logic      [PINS-1:0] pin_oe_n,
    output logic      [PINS-1:0] pin_pullup_en,
    // mapping controller side
    input  wire logic [PINS-1:0] alt_out,
    input  wire logic [PINS-1:0] alt_oe,
    output logic      [PINS-1:0] alt_in,
    output logic      [PINS-1:0] alt_sel,
    // analog converter side
    output logic      [PINS-1:0] adc_pin_avail,
    output logic                 nbr_pin0_analog,
    output logic                 nbr_pin0_gpio
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // address compare, used by both write and read decode
    function automatic logic hit(input addr_t a, input addr_t target);
        return a == target;
    endfunction

    // data read view: stored bit on outputs, pin level on inputs
    function automatic byte_t data_view(input byte_t dir, input byte_t data,
                                        input byte_t lvl);
        return ((dir & data) | (~dir & lvl)) & `PA_DATA_MASK;
    endfunction

    // ------------------------------------------------------------------------
    // state and pin level synchroniser
    // ------------------------------------------------------------------------

    regs_s            s_q;
    regs_s            s_d;
    logic [PINS-1:0]  pin_sync_lvl;
    byte_t            lvl_byte;

    pin_sync #(
        .WIDTH    (PINS)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (pin_in),
        .sync_out (pin_sync_lvl)
    );

    // pins occupy bits 7..4 of every register
    assign lvl_byte = {pin_sync_lvl, 4'h0};

    // ------------------------------------------------------------------------
    // register writes and read data
    // ------------------------------------------------------------------------

    // read data stands for exactly one cycle after the strobe, zero elsewhere
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = 8'h00;
        if (reg_wr)
        begin
            // unimplemented bits are never stored
            if (hit(reg_addr, `PA_FUNC_ADDR))
                s_d.func = reg_wdata & `PA_FUNC_MASK;   // R03
            if (hit(reg_addr, `PA_DIR_ADDR))
                s_d.dir  = reg_wdata & `PA_DIR_MASK;    // R03
            if (hit(reg_addr, `PA_DATA_ADDR))
                s_d.data = reg_wdata & `PA_DATA_MASK;
            if (hit(reg_addr, `PA_PULL_ADDR))
                s_d.pull = reg_wdata & `PA_PULL_MASK;
        end
        if (reg_rd)
        begin
            if (hit(reg_addr, `PA_FUNC_ADDR))
                s_d.rdata = s_q.func & `PA_FUNC_MASK;   // R03
            else if (hit(reg_addr, `PA_DIR_ADDR))
                s_d.rdata = s_q.dir & `PA_DIR_MASK;     // R03
            else if (hit(reg_addr, `PA_DATA_ADDR))
                s_d.rdata = data_view(s_q.dir, s_q.data, lvl_byte); // R06
            else if (hit(reg_addr, `PA_PULL_ADDR))
                s_d.rdata = s_q.pull & `PA_PULL_MASK;
            else
                s_d.rdata = 8'h00;                      // unmapped reads zero
        end
    end

    // all-zero reset leaves every pin a plain input
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            s_q.func  <= `PA_FUNC_RST;                  // R08
            s_q.dir   <= `PA_DIR_RST;                   // R08
            s_q.data  <= `PA_DATA_RST;
            s_q.pull  <= `PA_PULL_RST;
            s_q.rdata <= 8'h00;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata = s_q.rdata;

    // ------------------------------------------------------------------------
    // pin multiplexing
    // ------------------------------------------------------------------------

    pin_mux #(
        .WIDTH     (PINS)
    ) u_mux (
        .func      (s_q.func[`PA_PIN_HI:`PA_PIN_LO]),
        .dir       (s_q.dir[`PA_PIN_HI:`PA_PIN_LO]),
        .data      (s_q.data[`PA_PIN_HI:`PA_PIN_LO]),
        .pull      (s_q.pull[`PA_PIN_HI:`PA_PIN_LO]),
        .alt_out   (alt_out),
        .alt_oe    (alt_oe),
        .pin_out   (pin_out),
        .pin_oe_n  (pin_oe_n),
        .pullup_en (pin_pullup_en)
    );

    // ------------------------------------------------------------------------
    // alternate and analog routing
    // ------------------------------------------------------------------------

    // alternate inputs always see the synchronised pin, the select tells which
    assign alt_sel         = s_q.func[`PA_PIN_HI:`PA_PIN_LO];  // R01
    assign alt_in          = pin_sync_lvl;
    // analog sampling is only meaningful while nothing drives the pin
    assign adc_pin_avail   = pin_oe_n;                         // R05
    assign nbr_pin0_analog = s_q.func[`PA_ANALOG_BIT];         // R02
    assign nbr_pin0_gpio   = ~s_q.func[`PA_ANALOG_BIT];        // R02

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence func_write_s;
        reg_wr && hit(reg_addr, `PA_FUNC_ADDR);
    endsequence

    sequence data_read_s;
        reg_rd && hit(reg_addr, `PA_DATA_ADDR);
    endsequence

    sequence func_read_s;
        reg_rd && hit(reg_addr, `PA_FUNC_ADDR);
    endsequence

    sequence dir_write_s;
        reg_wr && hit(reg_addr, `PA_DIR_ADDR);
    endsequence

    sequence dir_read_s;
        reg_rd && hit(reg_addr, `PA_DIR_ADDR);
    endsequence

    sequence pull_write_s;
        reg_wr && hit(reg_addr, `PA_PULL_ADDR);
    endsequence

    sequence pull_read_s;
        reg_rd && hit(reg_addr, `PA_PULL_ADDR);
    endsequence

    // write, one quiet cycle, then read back: the usual pattern of a driver
    sequence func_write_read_s;
        func_write_s ##1 !reg_wr ##1 func_read_s;
    endsequence

    sequence dir_write_read_s;
        dir_write_s ##1 !reg_wr ##1 dir_read_s;
    endsequence

    sequence pull_write_read_s;
        pull_write_s ##1 !reg_wr ##1 pull_read_s;
    endsequence

    // a read that misses all four registers
    sequence unmapped_read_s;
        reg_rd && !hit(reg_addr, `PA_FUNC_ADDR) && !hit(reg_addr, `PA_DIR_ADDR)
        && !hit(reg_addr, `PA_DATA_ADDR) && !hit(reg_addr, `PA_PULL_ADDR);
    endsequence

    // mode write hands the pins to the mapping controller on the next cycle
    a_func_select_write: assert property ( // R01
        func_write_s |=> alt_sel == $past(reg_wdata[7:4]))
        else $error("alternate select does not follow mode write");

    // a selected pin carries the mapped value and drive untouched
    a_alt_pin_follow: assert property ( // R01
        ((pin_out & alt_sel) == (alt_out & alt_sel))
        && ((~pin_oe_n & alt_sel) == (alt_oe & alt_sel)))
        else $error("alternate pin does not follow mapping controller");

    // alternate inputs lag the pin by exactly the two synchroniser stages
    a_alt_in_sync: assert property ( // R01
        $past(nrst) && $past(nrst, 2) |-> alt_in == $past(pin_in, 2))
        else $error("alternate input does not track the pin");

    // neighbour pin routing follows the mode write
    a_analog_route: assert property ( // R02
        func_write_s |=> nbr_pin0_analog == $past(reg_wdata[2])
                         && nbr_pin0_gpio != nbr_pin0_analog)
        else $error("neighbour pin analog route wrong");

    // only a mode write may move the neighbour pin between its two uses
    a_analog_hold: assert property ( // R02
        !(reg_wr && hit(reg_addr, `PA_FUNC_ADDR)) |=> $stable(nbr_pin0_analog))
        else $error("neighbour pin route changed without a mode write");

    // unimplemented bits of mode and direction never read back set
    a_reserved_zero: assert property ( // R03
        reg_rd && (hit(reg_addr, `PA_FUNC_ADDR) || hit(reg_addr, `PA_DIR_ADDR))
        |=> (reg_rdata & 8'h0b) == 8'h00
            && ($past(hit(reg_addr, `PA_DIR_ADDR)) -> reg_rdata[3:0] == 4'h0))
        else $error("unimplemented bit read back nonzero");

    // mode read back returns the written implemented bits only
    a_func_readback: assert property ( // R03
        func_write_read_s |=> reg_rdata == ($past(reg_wdata, 3) & `PA_FUNC_MASK))
        else $error("mode register read back wrong");

    // direction read back returns the written implemented bits only
    a_dir_readback: assert property ( // R03
        dir_write_read_s |=> reg_rdata == ($past(reg_wdata, 3) & `PA_DIR_MASK))
        else $error("direction register read back wrong");

    // direction bit drives a general pin, alt_oe a mapped one
    a_gpio_direction: assert property ( // R04
        pin_oe_n == ~((~alt_sel & s_q.dir[7:4]) | (alt_sel & alt_oe)))
        else $error("general i/o drive does not follow direction");

    // a data write reaches every general pin on the next cycle
    a_gpio_out_value: assert property ( // R04
        reg_wr && hit(reg_addr, `PA_DATA_ADDR) |=>
        (pin_out & ~alt_sel) == ($past(reg_wdata[7:4]) & ~alt_sel))
        else $error("general output value not driven");

    // analog use is offered exactly on the pins that nothing drives
    a_adc_avail: assert property ( // R05
        adc_pin_avail == ~((~s_q.func[7:4] & s_q.dir[7:4]) | (s_q.func[7:4] & alt_oe)))
        else $error("analog availability disagrees with drive");

    // stored bit on outputs, synchronised level on inputs
    a_data_readback: assert property ( // R06
        data_read_s |=> reg_rdata == {(($past(s_q.dir[7:4]) & $past(s_q.data[7:4]))
                         | (~$past(s_q.dir[7:4]) & $past(pin_sync_lvl))), 4'h0})
        else $error("data read returns wrong view");

    // pull-up follows its bit on undriven pins only
    a_pullup_gate: assert property ( // R07
        pin_pullup_en == (s_q.pull[7:4] & pin_oe_n))
        else $error("pull-up active on a driven pin");

    // a driven pin never fights its own pull-up
    a_pull_off_driven: assert property ( // R07
        (pin_pullup_en & ~pin_oe_n) == '0)
        else $error("pull-up enabled on a driven pin");

    // pull-up read back returns the written implemented bits only
    a_pull_readback: assert property ( // R07
        pull_write_read_s |=> reg_rdata == ($past(reg_wdata, 3) & `PA_PULL_MASK))
        else $error("pull-up register read back wrong");

    // read data stand one cycle only, so a later read cannot see stale data
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");

    // unmapped places read zero rather than the last register touched
    a_unmapped_zero: assert property (
        unmapped_read_s |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero data");

    // first cycle out of reset: every pin a plain input
    a_reset_state: assert property ( // R08
        $rose(nrst) |-> pin_oe_n == '1 && alt_sel == '0 && !nbr_pin0_analog)
        else $error("pins not plain inputs after reset");

    // first cycle out of reset: no drive value, pull-up or read data left over
    a_reset_outputs: assert property ( // R08
        $rose(nrst) |-> reg_rdata == 8'h00 && pin_out == '0 && pin_pullup_en == '0
                        && adc_pin_avail == '1 && nbr_pin0_gpio)
        else $error("outputs not at reset values after reset");

endmodule

// *** sim/testbench.sv ***
// self-checking testbench of the port A pin control block
`timescale 1ns/100ps
`include "port_a_defs.svh"
module testbench;
    import port_a_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        core_clk;
    logic        nrst;
    logic [23:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe_n;
    logic [3:0]  pin_pullup_en;
    logic [3:0]  alt_out;
    logic [3:0]  alt_oe;
    logic [3:0]  alt_in;
    logic [3:0]  alt_sel;
    logic [3:0]  adc_pin_avail;
    logic        nbr_pin0_analog;
    logic        nbr_pin0_gpio;
    int          mismatches;
    int          n_checks;
    int          cycles;

    port_a_ctrl #(.PINS(4)) i_port_a_ctrl (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .pin_in          (pin_in),
        .pin_out         (pin_out),
        .pin_oe_n        (pin_oe_n),
        .pin_pullup_en   (pin_pullup_en),
        .alt_out         (alt_out),
        .alt_oe          (alt_oe),
        .alt_in          (alt_in),
        .alt_sel         (alt_sel),
        .adc_pin_avail   (adc_pin_avail),
        .nbr_pin0_analog (nbr_pin0_analog),
        .nbr_pin0_gpio   (nbr_pin0_gpio)
    );

    // ------------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------------
    // 8 ns period
    always #4 core_clk = ~core_clk;

    // the whole sequence needs under a hundred cycles, so 5000 means a hang
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe; returns once the register has taken it
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [23:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("read %h", a), exp, reg_rdata);
    endtask

    // lets the pin synchroniser settle before pin levels are looked at
    task automatic pins(input logic [3:0] lvl);
        @(posedge core_clk);
        pin_in <= lvl;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        core_clk  = 1'b0;
        nrst      = 1'b0;
        reg_addr  = 24'h000000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        pin_in    = 4'h0;
        alt_out   = 4'h0;
        alt_oe    = 4'h0;
        mismatches = 0;
        n_checks   = 0;
        cycles     = 0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        // reset state: every pin a general input, nothing routed away
        chk("oe_n", 8'h0f, {4'h0, pin_oe_n});
        chk("alt_sel", 8'h00, {4'h0, alt_sel});
        chk("nbr_gpio", 8'h01, {7'h00, nbr_pin0_gpio});
        chk("nbr_analog", 8'h00, {7'h00, nbr_pin0_analog});
        rd(`PA_FUNC_ADDR, 8'h00);
        rd(`PA_DIR_ADDR, 8'h00);
        rd(`PA_PULL_ADDR, 8'h00);
        // implemented bits set, unimplemented bits written zero and read zero
        wr(`PA_FUNC_ADDR, 8'hf4);
        rd(`PA_FUNC_ADDR, 8'hf4);
        chk("alt_sel", 8'h0f, {4'h0, alt_sel});
        chk("nbr_analog", 8'h01, {7'h00, nbr_pin0_analog});
        chk("nbr_gpio", 8'h00, {7'h00, nbr_pin0_gpio});
        wr(`PA_DIR_ADDR, 8'hf0);
        rd(`PA_DIR_ADDR, 8'hf0);
        // unmapped place: write ignored, read zero
        wr(24'hff0010, 8'h5a);
        rd(24'hff0010, 8'h00);
        rd(`PA_FUNC_ADDR, 8'hf4);
        // general outputs drive stored data
        wr(`PA_FUNC_ADDR, 8'h00);
        wr(`PA_DATA_ADDR, 8'ha0);
        chk("nbr_gpio", 8'h01, {7'h00, nbr_pin0_gpio});
        chk("oe_n", 8'h00, {4'h0, pin_oe_n});
        chk("pin_out", 8'h0a, {4'h0, pin_out});
        pins(4'h5);
        rd(`PA_DATA_ADDR, 8'ha0);
        wr(`PA_PULL_ADDR, 8'hf0);
        rd(`PA_PULL_ADDR, 8'hf0);
        chk("pullup", 8'h00, {4'h0, pin_pullup_en});
        // general inputs: live level read, pull-up active
        wr(`PA_DIR_ADDR, 8'h00);
        chk("oe_n", 8'h0f, {4'h0, pin_oe_n});
        chk("pullup", 8'h0f, {4'h0, pin_pullup_en});
        chk("adc", 8'h0f, {4'h0, adc_pin_avail});
        rd(`PA_DATA_ADDR, 8'h50);
        pins(4'ha);
        rd(`PA_DATA_ADDR, 8'ha0);
        // mixed: pins 4 and 6 alternate, 5 and 7 general outputs
        wr(`PA_DIR_ADDR, 8'hf0);
        wr(`PA_FUNC_ADDR, 8'h54);
        chk("alt_sel", 8'h05, {4'h0, alt_sel});
        chk("oe_n", 8'h05, {4'h0, pin_oe_n});
        chk("pin_out", 8'h0a, {4'h0, pin_out & 4'ha});
        chk("pullup", 8'h05, {4'h0, pin_pullup_en});
        // all alternate: the mapped function decides drive, direction is ignored
        @(posedge core_clk);
        alt_oe  <= 4'h5;
        alt_out <= 4'h3;
        wr(`PA_FUNC_ADDR, 8'hf0);
        chk("oe_n", 8'h0a, {4'h0, pin_oe_n});
        chk("pin_out", 8'h01, {4'h0, pin_out & 4'h5});
        chk("adc", 8'h0a, {4'h0, adc_pin_avail});
        chk("pullup", 8'h0a, {4'h0, pin_pullup_en});
        chk("nbr_analog", 8'h00, {7'h00, nbr_pin0_analog});
        pins(4'h6);
        chk("alt_in", 8'h06, {4'h0, alt_in});
        // reset in mid-run brings everything back to general inputs
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("alt_sel", 8'h00, {4'h0, alt_sel});
        chk("oe_n", 8'h0f, {4'h0, pin_oe_n});
        chk("pullup", 8'h00, {4'h0, pin_pullup_en});
        rd(`PA_DIR_ADDR, 8'h00);
        summarize();
    end
endmodule
